// [rtl/sle_pkg.sv]
/*
 Constants, types and register map of the step link condition evaluator.
 Assumes one core clock and a plain register port from host software.
*/
package sle_pkg;

   // Widths
   localparam int unsigned SLE_AW = 8;
   localparam int unsigned SLE_DW = 32;
   localparam int unsigned SLE_VW = 16;
   localparam int unsigned SLE_SW = 8;
   localparam int unsigned SLE_NAX = 8;

   // Register byte offsets
   localparam logic [7:0] SLE_REG_CTRL = 8'h00;
   localparam logic [7:0] SLE_REG_STATUS = 8'h04;
   localparam logic [7:0] SLE_REG_MODE = 8'h08;
   localparam logic [7:0] SLE_REG_LTYPE = 8'h0c;
   localparam logic [7:0] SLE_REG_LVAL = 8'h10;
   localparam logic [7:0] SLE_REG_LNEXT = 8'h14;
   localparam logic [7:0] SLE_REG_CUR = 8'h18;
   localparam logic [7:0] SLE_REG_MATH = 8'h1c;
   localparam logic [7:0] SLE_REG_POSSGN = 8'h20;

   // Control, status, math and mode bit positions
   localparam int unsigned SLE_CTRL_GO = 0;
   localparam int unsigned SLE_CTRL_ABORT = 1;
   localparam int unsigned SLE_STAT_WAIT = 0;
   localparam int unsigned SLE_STAT_BRANCH = 1;
   localparam int unsigned SLE_STAT_UNSUP = 2;
   localparam int unsigned SLE_STAT_NEXT = 8;
   localparam int unsigned SLE_MATH_OVF = 16;
   localparam int unsigned SLE_MODE_AXIS_LSB = 4;
   localparam int unsigned SLE_MODE_AXIS_W = 3;

   // Link type codes
   localparam logic [7:0] SLE_EQUAL_TEST = 8'h10;
   localparam logic [7:0] SLE_NOT_EQUAL_TEST = 8'h11;
   localparam logic [7:0] SLE_NO_OVERFLOW_TEST = 8'h12;
   localparam logic [7:0] SLE_OVERFLOW_TEST = 8'h13;
   localparam logic [7:0] SLE_SIGNED_LE = 8'h14;
   localparam logic [7:0] SLE_UNSIGNED_LE = 8'h18;
   localparam logic [7:0] SLE_POSITION_LE = 8'h1c;
   localparam logic [7:0] SLE_MULTI_AXIS_SETTLED_WAIT = 8'h41;
   localparam logic [1:0] SLE_ORD_LE = 2'h0;
   localparam logic [1:0] SLE_ORD_LT = 2'h1;
   localparam logic [1:0] SLE_ORD_GT = 2'h2;

   // Reset values and step increment
   localparam logic [15:0] SLE_RST_V16 = 16'h0000;
   localparam logic [7:0] SLE_RST_V8 = 8'h00;
   localparam logic [7:0] SLE_STEP_INC = 8'h01;

   // Latest math command result of the sequence axis
   typedef struct packed {
      logic        valid;
      logic [15:0] result;
      logic        ovf;
   } sle_math_t;

   // Per-axis condition inputs
   typedef struct packed {
      logic [7:0] present;
      logic [7:0] pressure;
      logic [7:0] in_pos;
      logic [7:0] at_press;
   } sle_axis_t;

   typedef enum logic [1:0] {SLE_IDLE, SLE_EVAL, SLE_WAIT} sle_state_t;

endpackage : sle_pkg

// [rtl/sle_cond.sv]
/*
 Combinational condition of the math compare link family.
 Assumes operands are stable while the evaluator samples the result.
*/
`timescale 1ns/1ns
`default_nettype none
module sle_cond
   import sle_pkg::*;
(
   // Step fields
   input  wire logic [7:0]  link_type_i,
   input  wire logic [15:0] link_value_i,
   input  wire logic        pos_signed_i,
   // Math result
   input  wire logic [15:0] result_i,
   input  wire logic        ovf_i,
   // Outcome
   output logic             cond_o,
   output logic             known_o
);

   // Ordering outcome from less and equal flags
   function automatic logic ord_pick(input logic lt, input logic eq, input logic [1:0] sel);
      logic r;
      r = 1'b0;
      if (sel == SLE_ORD_LE) r = lt | eq;
      else if (sel == SLE_ORD_LT) r = lt;
      else if (sel == SLE_ORD_GT) r = ~(lt | eq);
      else r = ~lt;
      return r;
   endfunction : ord_pick

   logic eq;
   logic lt_s;
   logic lt_u;
   logic [1:0] sel;

   // Bitwise equality and two ways of ordering
   assign eq   = (result_i == link_value_i);
   assign lt_s = ($signed(result_i) < $signed(link_value_i));
   assign lt_u = (result_i < link_value_i);
   assign sel  = link_type_i[1:0];

   // Decode of link family
   always_comb
   begin
      cond_o  = 1'b0;
      known_o = 1'b1;
      if (link_type_i == SLE_EQUAL_TEST) cond_o = eq;
      else if (link_type_i == SLE_NOT_EQUAL_TEST) cond_o = ~eq;
      else if (link_type_i == SLE_NO_OVERFLOW_TEST) cond_o = ~ovf_i;
      else if (link_type_i == SLE_OVERFLOW_TEST) cond_o = ovf_i;
      else if (link_type_i[7:2] == SLE_SIGNED_LE[7:2])
         cond_o = ord_pick(lt_s, eq, sel);
      else if (link_type_i[7:2] == SLE_UNSIGNED_LE[7:2])
         cond_o = ord_pick(lt_u, eq, sel);
      else if (link_type_i[7:2] == SLE_POSITION_LE[7:2])
         cond_o = ord_pick(pos_signed_i ? lt_s : lt_u, eq, sel);
      else known_o = 1'b0;
   end

endmodule : sle_cond
`default_nettype wire

// [rtl/sle_eval.sv]
/*
 Step link condition evaluator: register port, math result latch,
 math compare branch and multi-axis settled wait.
 Assumes synchronous inputs, one core clock and a single-cycle register port.
*/
// The implementer's own choices: the register addresses and the strobed register port.
`timescale 1ns/1ns
`default_nettype none
module sle_eval
   import sle_pkg::*;
#(
   parameter int unsigned NUM_AXES = SLE_NAX
)
(
   // Clock and reset
   input  wire logic              core_clk_i,
   input  wire logic              reset_i,
   // Register port
   input  wire logic [SLE_AW-1:0] addr_i,
   input  wire logic [SLE_DW-1:0] wdata_i,
   input  wire logic              wr_i,
   input  wire logic              rd_i,
   output logic [SLE_DW-1:0]      rdata_o,
   // Math command results of the sequence axis
   input  wire sle_math_t         math_i,
   // Axis condition inputs
   input  wire sle_axis_t         axis_i,
   // Evaluation outcome
   output logic [SLE_SW-1:0]      next_step_o,
   output logic                   step_done_o,
   output logic                   branch_o,
   output logic                   waiting_o
);

   // Complete state of the block
   typedef struct packed {
      sle_state_t       st;
      logic [15:0]      mode;
      logic [7:0]       ltype;
      logic [15:0]      lval;
      logic [7:0]       lnext;
      logic [7:0]       cur;
      logic [15:0]      res;
      logic             ovf;
      logic [7:0]       pos_signed;
      logic [7:0]       next_step;
      logic             done;
      logic             branch;
      logic             waiting;
      logic             unsup;
      logic [31:0]      rdata;
   } sle_regs_t;

   sle_regs_t r_ff;
   sle_regs_t nxt_r;

   // Combinational helpers
   logic [15:0] use_res;
   logic        use_ovf;
   logic [2:0]  axis_sel;
   logic        cond;
   logic        known;
   logic [7:0]  qualify;
   logic        all_ready;
   logic [7:0]  follow_step;
   logic        go;
   logic        abort;

   // Write strobe decode for one offset
   function automatic logic wr_hit(input logic wr,
                                   input logic [7:0] addr,
                                   input logic [7:0] off);
      return wr && (addr == off);
   endfunction : wr_hit

   // A math result in the evaluation cycle itself is used at once
   assign use_res = math_i.valid ? math_i.result : r_ff.res;
   assign use_ovf = math_i.valid ? math_i.ovf : r_ff.ovf;

   // Axis whose position range applies
   assign axis_sel = r_ff.mode[SLE_MODE_AXIS_LSB +: SLE_MODE_AXIS_W];

   // Step after the current one, wrapping past the last step
   assign follow_step = r_ff.cur + SLE_STEP_INC;

   // Control strobes
   assign go    = wr_hit(wr_i, addr_i, SLE_REG_CTRL) && wdata_i[SLE_CTRL_GO];
   assign abort = wr_hit(wr_i, addr_i, SLE_REG_CTRL) && wdata_i[SLE_CTRL_ABORT];

   // Math compare condition
   sle_cond u_cond (
      .link_type_i  (r_ff.ltype),
      .link_value_i (r_ff.lval),
      .pos_signed_i (r_ff.pos_signed[axis_sel]),
      .result_i     (use_res),
      .ovf_i        (use_ovf),
      .cond_o       (cond),
      .known_o      (known)
   );

   // Per-axis qualification for the settled wait
   always_comb
   begin
      qualify = '0;
      for (int n = 0; n < SLE_NAX; n++)
      begin
         if (n < NUM_AXES)
         begin
            qualify[n] = axis_i.present[n] &&
                         (axis_i.pressure[n] ? axis_i.at_press[n]
                                             : axis_i.in_pos[n]);
         end
      end
   end

   // All masked axes must qualify in the same cycle
   assign all_ready = &(qualify | ~r_ff.lval[7:0]);

   // Next state
   always_comb
   begin
      nxt_r = r_ff;
      nxt_r.done = 1'b0;
      nxt_r.rdata = '0;

      // Latest math command result is held until the next one
      if (math_i.valid)
      begin
         nxt_r.res = math_i.result;
         nxt_r.ovf = math_i.ovf;
      end

      // Register writes
      if (wr_hit(wr_i, addr_i, SLE_REG_MODE))
      begin
         nxt_r.mode = wdata_i[15:0];
      end
      else if (wr_hit(wr_i, addr_i, SLE_REG_LTYPE))
      begin
         nxt_r.ltype = wdata_i[7:0];
      end
      else if (wr_hit(wr_i, addr_i, SLE_REG_LVAL))
      begin
         nxt_r.lval = wdata_i[15:0];
      end
      else if (wr_hit(wr_i, addr_i, SLE_REG_LNEXT))
      begin
         nxt_r.lnext = wdata_i[7:0];
      end
      else if (wr_hit(wr_i, addr_i, SLE_REG_CUR))
      begin
         nxt_r.cur = wdata_i[7:0];
      end
      else if (wr_hit(wr_i, addr_i, SLE_REG_POSSGN))
      begin
         nxt_r.pos_signed = wdata_i[7:0];
      end

      // Register reads, data in the following cycle only
      if (rd_i)
      begin
         if (addr_i == SLE_REG_STATUS)
         begin
            nxt_r.rdata[SLE_STAT_WAIT]   = (r_ff.st != SLE_IDLE);
            nxt_r.rdata[SLE_STAT_BRANCH] = r_ff.branch;
            nxt_r.rdata[SLE_STAT_UNSUP]  = r_ff.unsup;
            nxt_r.rdata[SLE_STAT_NEXT +: SLE_SW] = r_ff.next_step;
         end
         else if (addr_i == SLE_REG_MODE)
         begin
            nxt_r.rdata[15:0] = r_ff.mode;
         end
         else if (addr_i == SLE_REG_LTYPE)
         begin
            nxt_r.rdata[7:0] = r_ff.ltype;
         end
         else if (addr_i == SLE_REG_LVAL)
         begin
            nxt_r.rdata[15:0] = r_ff.lval;
         end
         else if (addr_i == SLE_REG_LNEXT)
         begin
            nxt_r.rdata[7:0] = r_ff.lnext;
         end
         else if (addr_i == SLE_REG_CUR)
         begin
            nxt_r.rdata[7:0] = r_ff.cur;
         end
         else if (addr_i == SLE_REG_MATH)
         begin
            nxt_r.rdata[15:0] = r_ff.res;
            nxt_r.rdata[SLE_MATH_OVF] = r_ff.ovf;
         end
         else if (addr_i == SLE_REG_POSSGN)
         begin
            nxt_r.rdata[7:0] = r_ff.pos_signed;
         end
      end

      // Sequencer of one link evaluation
      case (r_ff.st)
         SLE_IDLE:
         begin
            if (go)
            begin
               nxt_r.st = SLE_EVAL;
            end
         end
         SLE_EVAL:
         begin
            nxt_r.unsup  = 1'b0;
            nxt_r.done   = 1'b1;
            nxt_r.st     = SLE_IDLE;
            if (abort)
            begin
               nxt_r.done = 1'b0;
            end
            else if (r_ff.ltype == SLE_MULTI_AXIS_SETTLED_WAIT)
            begin
               nxt_r.done = 1'b0;
               nxt_r.st   = SLE_WAIT;
            end
            else if (known)
            begin
               // No wait: branch or fall through
               nxt_r.branch    = cond;
               nxt_r.next_step = cond ? r_ff.lnext : follow_step;
            end
            else
            begin
               // Codes outside this block fall through and flag it
               nxt_r.unsup     = 1'b1;
               nxt_r.branch    = 1'b0;
               nxt_r.next_step = follow_step;
            end
         end
         SLE_WAIT:
         begin
            if (abort)
            begin
               nxt_r.st = SLE_IDLE;
            end
            else if (all_ready)
            begin
               nxt_r.branch    = 1'b1;
               nxt_r.next_step = r_ff.lnext;
               nxt_r.done      = 1'b1;
               nxt_r.st        = SLE_IDLE;
            end
            // Otherwise keep waiting, forever if a masked axis is absent
         end
         default:
         begin
            nxt_r.st = SLE_IDLE;
         end
      endcase

      // Wait flag kept in its own flop so the port needs no decode
      nxt_r.waiting = (nxt_r.st == SLE_WAIT);
   end

   // State register
   always_ff @(posedge core_clk_i)
   begin
      if (reset_i)
      begin
         r_ff.st         <= SLE_IDLE;
         r_ff.mode       <= SLE_RST_V16;
         r_ff.ltype      <= SLE_RST_V8;
         r_ff.lval       <= SLE_RST_V16;
         r_ff.lnext      <= SLE_RST_V8;
         r_ff.cur        <= SLE_RST_V8;
         r_ff.res        <= SLE_RST_V16;
         r_ff.ovf        <= 1'b0;
         r_ff.pos_signed <= SLE_RST_V8;
         r_ff.next_step  <= SLE_RST_V8;
         r_ff.done       <= 1'b0;
         r_ff.branch     <= 1'b0;
         r_ff.waiting    <= 1'b0;
         r_ff.unsup      <= 1'b0;
         r_ff.rdata      <= '0;
      end
      else
      begin
         r_ff <= nxt_r;
      end
   end

   // Outputs straight from the state register
   assign rdata_o     = r_ff.rdata;
   assign next_step_o = r_ff.next_step;
   assign step_done_o = r_ff.done;
   assign branch_o    = r_ff.branch;
   assign waiting_o   = r_ff.waiting;

endmodule : sle_eval
`default_nettype wire

// [sim/sle_eval_checker.sv]
/*
 Concurrent checks on the ports of the step link evaluator.
 Assumes one core clock, synchronous active-high reset and a quiet bus while an evaluation runs.
*/
`timescale 1ns/1ns
`default_nettype none
module sle_eval_checker
   import sle_pkg::*;
#(
   parameter int unsigned NUM_AXES = SLE_NAX
)
(
   // Clock and reset
   input  wire logic              core_clk_i,
   input  wire logic              reset_i,
   // Register port
   input  wire logic [SLE_AW-1:0] addr_i,
   input  wire logic [SLE_DW-1:0] wdata_i,
   input  wire logic              wr_i,
   // Axis levels
   input  wire sle_axis_t         axis_i,
   // Outcome
   input  wire logic [SLE_SW-1:0] next_step_o,
   input  wire logic              step_done_o,
   input  wire logic              branch_o,
   input  wire logic              waiting_o
);
   logic [7:0]  lt_ff;
   logic [7:0]  ln_ff;
   logic [7:0]  cu_ff;
   logic [15:0] lv_ff;
   logic        busy_ff;
   logic [7:0]  am;
   logic [7:0]  qual;
   logic        go;
   logic        abt;
   logic        blk;

   // Decode control writes and which axes qualify now
   assign go   = wr_i && (addr_i == SLE_REG_CTRL) && wdata_i[SLE_CTRL_GO];
   assign abt  = wr_i && (addr_i == SLE_REG_CTRL) && wdata_i[SLE_CTRL_ABORT];
   assign am   = 8'((9'h001 << NUM_AXES) - 9'h001);
   assign qual = am & axis_i.present & ((axis_i.pressure & axis_i.at_press) | (~axis_i.pressure & axis_i.in_pos));
   assign blk  = |(lv_ff[7:0] & ~qual);

   // Shadow of the step fields and of the busy state
   always_ff @(posedge core_clk_i)
   begin
      if (reset_i)
      begin
         lt_ff   <= 8'h00;
         ln_ff   <= 8'h00;
         cu_ff   <= 8'h00;
         lv_ff   <= 16'h0000;
         busy_ff <= 1'b0;
      end
      else
      begin
         if (wr_i && addr_i == SLE_REG_LTYPE) lt_ff <= wdata_i[7:0];
         if (wr_i && addr_i == SLE_REG_LNEXT) ln_ff <= wdata_i[7:0];
         if (wr_i && addr_i == SLE_REG_CUR) cu_ff <= wdata_i[7:0];
         if (wr_i && addr_i == SLE_REG_LVAL) lv_ff <= wdata_i[15:0];
         busy_ff <= (go && !busy_ff) ? 1'b1 : ((step_done_o || abt) ? 1'b0 : busy_ff);
      end
   end

   default clocking @(posedge core_clk_i); endclocking
   default disable iff (reset_i);

   // Math links answer two cycles after go, without waiting
   property p_math_done;
      go && !busy_ff && lt_ff != SLE_MULTI_AXIS_SETTLED_WAIT ##1 !abt |-> ##1 step_done_o;
   endproperty
   a_math_done: assert property (p_math_done) else $error("math link did not finish in two cycles");
   property p_done_pulse;
      step_done_o |=> !step_done_o;
   endproperty
   a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");
   property p_next_sel;
      step_done_o |-> next_step_o == (branch_o ? ln_ff : cu_ff + 8'h01);
   endproperty
   a_next_sel: assert property (p_next_sel) else $error("wrong next step");
   property p_hold;
      !step_done_o |-> $stable(next_step_o) && $stable(branch_o);
   endproperty
   a_hold: assert property (p_hold) else $error("outcome changed without done");
   property p_wait_enter;
      go && !busy_ff && lt_ff == SLE_MULTI_AXIS_SETTLED_WAIT ##1 !abt |-> ##1 waiting_o;
   endproperty
   a_wait_enter: assert property (p_wait_enter) else $error("wait not entered");
   property p_wait_block;
      waiting_o && blk |=> !step_done_o;
   endproperty
   a_wait_block: assert property (p_wait_block) else $error("wait left early");
   property p_wait_go;
      waiting_o && !blk && !abt |=> step_done_o && branch_o && !waiting_o;
   endproperty
   a_wait_go: assert property (p_wait_go) else $error("wait did not branch");
   property p_kind;
      waiting_o && |(lv_ff[7:0] & ~axis_i.pressure & ~axis_i.in_pos) |=> !step_done_o;
   endproperty
   a_kind: assert property (p_kind) else $error("position axis not in place passed");

   // Main scenarios
   c_math: cover property (go ##2 step_done_o && !waiting_o);
   c_release: cover property (waiting_o ##1 step_done_o);
   c_abort: cover property (waiting_o && abt);
endmodule : sle_eval_checker

bind sle_eval sle_eval_checker #(.NUM_AXES(NUM_AXES)) u_chk (
   .core_clk_i  (core_clk_i),
   .reset_i     (reset_i),
   .addr_i      (addr_i),
   .wdata_i     (wdata_i),
   .wr_i        (wr_i),
   .axis_i      (axis_i),
   .next_step_o (next_step_o),
   .step_done_o (step_done_o),
   .branch_o    (branch_o),
   .waiting_o   (waiting_o)
);
`default_nettype wire

// [sim/test_step_link_condition_eval.sv]
/*
 Self-checking bench of the step link evaluator: every math code, then the multi-axis wait.
 Assumes the package and the evaluator are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module test_step_link_condition_eval
   import sle_pkg::*;
;
   logic        core_clk_i = 1'b0;
   logic        reset_i    = 1'b1;
   logic [7:0]  addr_i     = 8'h00;
   logic [31:0] wdata_i    = 32'h0;
   logic        wr_i       = 1'b0;
   logic        rd_i       = 1'b0;
   logic [31:0] rdata_o;
   sle_math_t   math_i     = '0;
   sle_axis_t   axis_i     = '0;
   logic [7:0]  next_step_o;
   logic        step_done_o;
   logic        branch_o;
   logic        waiting_o;
   int          num_errors = 0;
   int          tests_run  = 0;
   int          cyc        = 0;
   logic        rd_pend    = 1'b0;
   logic [8:0]  exp_q[$];
   logic [31:0] rd_q[$];

   // Clock of 20 ns
   always #10 core_clk_i = ~core_clk_i;

   sle_eval #(.NUM_AXES(6)) dut_u (
      .core_clk_i (core_clk_i), .reset_i (reset_i), .addr_i (addr_i), .wdata_i (wdata_i),
      .wr_i (wr_i), .rd_i (rd_i), .rdata_o (rdata_o), .math_i (math_i), .axis_i (axis_i),
      .next_step_o (next_step_o), .step_done_o (step_done_o), .branch_o (branch_o), .waiting_o (waiting_o)
   );

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic finish_test;
      if (num_errors == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : finish_test

   // Hang guard
   always @(posedge core_clk_i)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         num_errors++;
         finish_test();
      end
   end

   // Watch outputs and take the oldest note when a result appears
   always @(negedge core_clk_i)
   begin
      if (rd_pend)
         chk(rdata_o, rd_q.pop_front());
      rd_pend = rd_i && !reset_i;
      if (step_done_o === 1'b1)
         chk({23'h0, branch_o, next_step_o}, exp_q.size() ? {23'h0, exp_q.pop_front()} : 32'hffff);
   end

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge core_clk_i);
      wr_i <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge core_clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      rd_q.push_back(e);
      @(posedge core_clk_i);
      rd_i <= 1'b0;
   endtask : rd

   task automatic wait_done;
      int n;
      for (n = 0; n < 40; n++)
      begin
         @(negedge core_clk_i);
         if (step_done_o === 1'b1)
            break;
      end
      if (n == 40)
         chk(32'h0, 32'h1);
   endtask : wait_done

   // Reference condition of a math link
   function automatic logic expc(input logic [7:0] c, input logic [15:0] r, input logic [15:0] v,
                                 input logic o, input logic sg);
      logic s;
      logic lt;
      logic eq;
      s = (c[3:2] == 2'h1) || (c[3:2] == 2'h3 && sg);
      lt = s ? ($signed(r) < $signed(v)) : (r < v);
      eq = (r == v);
      if (c[7:4] != 4'h1)
         return 1'b0; // Codes outside the math family never branch
      if (c[3:2] == 2'h0)
         case (c[1:0])
            2'h0: return eq;
            2'h1: return !eq;
            2'h2: return !o;
            default: return o;
         endcase
      case (c[1:0])
         2'h0: return lt || eq;
         2'h1: return lt;
         2'h2: return !lt && !eq;
         default: return !lt;
      endcase
   endfunction : expc

   // One math link step; odd k delivers the math result on the step itself
   task automatic eval(input logic [7:0] c, input int k);
      logic [15:0] r;
      logic [15:0] v;
      logic        o;
      logic [2:0]  ax;
      logic [7:0]  ln;
      logic [7:0]  cu;
      logic [7:0]  ps;
      logic        b;
      logic [7:0]  nx;
      r = 16'($urandom);
      v = 16'($urandom);
      o = 1'($urandom);
      ax = 3'($urandom);
      ln = 8'($urandom);
      ps = 8'($urandom);
      cu = (k == 0) ? 8'hff : 8'($urandom);
      if (k % 3 == 0) v = r;
      if (k % 3 == 1) v = r ^ 16'h8000;
      if (c[3:2] != 2'h0) o = 1'b0; // ordering compares only see results without overflow
      b = expc(c, r, v, o, ps[ax]);
      nx = b ? ln : cu + 8'h01;
      wr(SLE_REG_MODE, {25'h0, ax, 4'h0});
      wr(SLE_REG_LTYPE, {24'h0, c});
      wr(SLE_REG_LVAL, {16'h0, v});
      wr(SLE_REG_LNEXT, {24'h0, ln});
      wr(SLE_REG_CUR, {24'h0, cu});
      wr(SLE_REG_POSSGN, {24'h0, ps});
      if (!k[0])
      begin
         @(posedge core_clk_i);
         math_i <= {1'b1, r, o};
         @(posedge core_clk_i);
         math_i.valid <= 1'b0;
         rd(SLE_REG_MATH, {15'h0, o, r});
      end
      exp_q.push_back({b, nx});
      wr(SLE_REG_CTRL, 32'h1);
      if (k[0]) math_i <= {1'b1, r, o};
      @(posedge core_clk_i);
      math_i.valid <= 1'b0;
      wait_done();
      // Status after the step: idle, branch, unsupported flag and chosen step
      rd(SLE_REG_STATUS, {16'h0, nx, 5'h0, (c[7:4] != 4'h1), b, 1'b0});
   endtask : eval

   // Multi-axis wait: h cycles with wrong-kind readiness, then release or abort
   task automatic wt(input logic [7:0] m, input logic [7:0] pr, input int h, input logic rel);
      logic [7:0] p;
      logic [7:0] ln;
      p = 8'($urandom);
      ln = 8'($urandom);
      @(posedge core_clk_i);
      axis_i <= {pr, p, (h != 0) ? p : ~p, (h != 0) ? ~p : p};
      wr(SLE_REG_LTYPE, {24'h0, SLE_MULTI_AXIS_SETTLED_WAIT});
      wr(SLE_REG_LVAL, {16'h0, 8'($urandom), m});
      wr(SLE_REG_LNEXT, {24'h0, ln});
      if (rel) exp_q.push_back({1'b1, ln});
      wr(SLE_REG_CTRL, 32'h1);
      repeat (h) @(posedge core_clk_i);
      // Every present axis below NUM_AXES now qualifies; only a missing axis or one at or above NUM_AXES can hold the wait
      axis_i.in_pos <= ~p;
      axis_i.at_press <= p;
      if (rel)
         wait_done();
      else
      begin
         repeat (4) @(negedge core_clk_i);
         chk({31'h0, waiting_o}, 32'h1);
         wr(SLE_REG_CTRL, 32'h2);
         @(negedge core_clk_i);
         chk({31'h0, waiting_o}, 32'h0);
      end
   endtask : wt

   // Main sequence
   initial
   begin
      void'($urandom(49));
      repeat (4) @(posedge core_clk_i);
      reset_i <= 1'b0;
      rd(8'h3c, 32'h0);
      for (int c = 16; c < 33; c++)
         for (int k = 0; k < 8; k++)
            eval(8'(c), k);
      wt(8'h00, 8'hff, 0, 1'b1);
      wt(8'h2d, 8'hff, 6, 1'b1);
      wt(8'h0c, 8'hf7, 6, 1'b0);
      wt(8'h80, 8'hff, 6, 1'b0);
      finish_test();
   end
endmodule : test_step_link_condition_eval
`default_nettype wire
